/* verilog/crt_card_read.sv */
// card read execute logic: buffer digits into storage words
// Operation
// - lockout digit decoded by its parity
// - control word option decoded by parity
// - missing seven zeros drops final word
// - band 8 alone gives no-format alarm
// - only even lockout digit clears reload lockout
// - pointer starts at base, decrements per word
// - pointer wraps modulo installed storage size
// - numeric format stores at most 13 words
// - numeric zero fill stopped by control word
// - transfer runs until band is exhausted
// - bad address stores no word at all
// - digit check on low position shift-out
// - word moves to holding register in halves
// - after error digits pile at sign end
// - alarm pointer is bad word address minus one
// - completion leaves pointer, shift register, counter
// - no-format or no-unit clears shift register
// - odd lockout digit imposes reload lockout
// - sign 6 or 7 word stops storing, fetched
// - eleven digits make one stored word
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module crt_card_read (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   input  wire crt_pkg::crt_buf_type buf_i,
   output crt_pkg::crt_mem_type      mem_o,
   output logic                      fetch_req,
   output logic      [43:0]          command_holding_word,
   output logic                      unit_release,
   output logic                      reload_lockout
);
   import crt_pkg::*;

   crt_state_type q;
   crt_state_type n;
   logic          stb;
   logic          start;

   // storage pointer step with wrap at the bottom of storage
   function automatic logic [11:0] ptr_dec(input logic [11:0] p);
      ptr_dec = (p == 12'h000) ? CRT_MEM_WORDS - 12'h001 : p - 12'h001;
   endfunction

   // codes above nine are impermissible digit configurations
   function automatic logic digit_bad(input logic [3:0] d);
      digit_bad = d > CRT_DIGIT_MAX;
   endfunction

   // a word may be written only while nothing has suppressed storing
   function automatic logic may_store(input crt_state_type s);
      may_store = !s.stop && !s.bad && !s.noaddr &&
                  !(s.numeric && s.wcnt >= CRT_NUM_WORDS);
   endfunction

   assign stb   = q.b2.strobe & ~q.stb3;
   assign start = q.wr_pend && q.widx == CRT_REG_CTRL &&
                  hwdata[CRT_GO_BIT] && !q.busy;

   // next state of the whole block
   always_comb begin
      logic [43:0] word;
      logic [7:0]  sel;
      word = 44'h00000000000;
      sel  = q.b2.fmt_sel;
      n = q;
      // buffer pins pass two flops before anything reads them
      n.b1 = buf_i;
      n.b2 = q.b1;
      n.stb3 = q.b2.strobe;
      n.hrdy = 1'b1;
      n.mem.we = 1'b0;
      n.fetch = 1'b0;
      n.release_u = 1'b0;

      // address phase: latch write, prepare read data for data phase
      n.wr_pend = 1'b0;
      if (hsel && hready && htrans[1]) begin
         n.wr_pend = hwrite;
         n.widx = haddr[4:0];
         n.hrdata = 32'h00000000;
         if (!hwrite) begin
            case (haddr[4:0])
               CRT_REG_CTRL: n.hrdata = {24'h000000, q.vdig, q.rdig};
               CRT_REG_BASE: n.hrdata = {20'h00000, q.base};
               CRT_REG_STATUS: n.hrdata = {22'h000000, q.fmt_lock,
                  q.reload_lock, q.bmod, q.stop, q.a_dchk, q.a_naddr,
                  q.a_nfmt, q.a_nunit, q.busy, 1'b0};
               CRT_REG_PTR: n.hrdata = {20'h00000, q.ptr};
               CRT_REG_PC: n.hrdata = {20'h00000, q.pc};
               default: n.hrdata = 32'h00000000;
            endcase
         end
      end

      // data phase writes; setup is frozen while a transfer runs
      if (q.wr_pend && !q.busy) begin
         case (q.widx)
            CRT_REG_CTRL: begin
               n.rdig = hwdata[CRT_LOCK_LSB +: 4];
               n.vdig = hwdata[CRT_CWOPT_LSB +: 4];
            end
            CRT_REG_BASE: n.base = hwdata[11:0];
            CRT_REG_PC: n.pc = hwdata[11:0];
            default: n.base = q.base;
         endcase
      end

      case (q.phase)
         CRT_IDLE: begin
            if (start) begin
               n.ptr = q.base;
               n.dcnt = 4'h0;
               n.wcnt = 4'h0;
               n.ib_full = 1'b0;
               n.stop = 1'b0;
               n.bad = 1'b0;
               n.bmod = 1'b0;
               n.a_nfmt = 1'b0;
               n.a_nunit = 1'b0;
               n.a_naddr = 1'b0;
               n.a_dchk = 1'b0;
               n.numeric = sel[CRT_FMT_NUMERIC];
               n.noaddr = q.base >= CRT_MEM_WORDS;
               n.busy = 1'b1;
               n.phase = CRT_XFER;
               // band 8 only with another band
               n.fmt_lock = sel[CRT_FMT_BAND8] && (|sel[6:0]);
               if (!q.b2.unit_ok || (|sel[6:0]) == 1'b0) begin
                  // clear shift register, pointer at base
                  n.a_nunit = !q.b2.unit_ok;
                  n.a_nfmt = q.b2.unit_ok;
                  n.fmt_lock = 1'b0;
                  n.dreg = 44'h00000000000;
                  n.pc = q.pc + 12'h001;
                  n.busy = 1'b0;
                  n.phase = CRT_IDLE;
               end
            end
         end
         CRT_XFER: begin
            // digits consumed to band end despite alarms
            if (stb) begin
               if (q.bad) begin
                  // digits pile up at the sign end
                  n.dreg[43:40] = q.b2.digit;
               end else if (digit_bad(q.dreg[3:0]) &&
                            (q.dcnt != 4'h0 || q.ib_full)) begin
                  // check on shift out of low position
                  n.bad = 1'b1;
                  // pointer one below the bad word
                  n.ptr = ptr_dec(q.ptr);
                  n.dreg[43:40] = q.b2.digit;
               end else begin
                  n.dreg = {q.dreg[39:0], q.b2.digit};
                  // holding word goes out while the next one fills
                  if (q.dcnt == 4'h0 && q.ib_full) begin
                     n.ib_full = 1'b0;
                     if (may_store(q)) begin
                        // write then step down with wrap
                        n.mem.we = 1'b1;
                        n.mem.addr = q.ptr;
                        n.mem.data = q.ib;
                        n.ptr = ptr_dec(q.ptr);
                        n.wcnt = q.wcnt + 4'h1;
                     end
                  end
                  // high part split off early, unchecked
                  if (q.dcnt == CRT_HI_LAST) begin
                     n.ib[43:20] = {q.dreg[19:0], q.b2.digit};
                  end
                  if (q.dcnt == CRT_LAST_DIGIT) begin
                     n.dcnt = 4'h0;
                     word = {q.ib[43:20], q.dreg[15:0], q.b2.digit};
                     // sign 8 or 9 with lockout digit 8 or 9
                     if (word[43:40] >= CRT_SIGN_BMOD &&
                         q.rdig >= CRT_SIGN_BMOD) begin
                        word[43:40] = word[43:40] - CRT_SIGN_BMOD;
                        n.bmod = 1'b1;
                     end
                     n.ib = word;
                     n.ib_full = 1'b1;
                     if (word[43:41] == CRT_SIGN_CW[3:1] &&
                         !q.vdig[0] && !q.stop) begin
                        n.stop = 1'b1;
                        n.cmd = word;
                        n.ib_full = 1'b0;
                     end
                  end else begin
                     n.dcnt = q.dcnt + 4'h1;
                  end
               end
            end else if (q.b2.band_end) begin
               // final word kept only with the seven zeros
               if (q.ib_full && may_store(q) && q.b2.zeros_ok) begin
                  n.mem.we = 1'b1;
                  n.mem.addr = q.ptr;
                  n.mem.data = q.ib;
                  n.ptr = ptr_dec(q.ptr);
                  n.wcnt = q.wcnt + 4'h1;
               end
               n.ib_full = 1'b0;
               n.phase = (q.numeric && may_store(q)) ? CRT_FILL : CRT_DONE;
            end
         end
         CRT_FILL: begin
            if (may_store(q)) begin
               n.mem.we = 1'b1;
               n.mem.addr = q.ptr;
               n.mem.data = 44'h00000000000;
               n.ptr = ptr_dec(q.ptr);
               n.wcnt = q.wcnt + 4'h1;
            end else begin
               n.phase = CRT_DONE;
            end
         end
         CRT_DONE: begin
            // finish: counter advanced, top digits cleared unless a digit check failed
            n.pc = q.pc + 12'h001;
            if (!q.bad) begin
               n.dreg = {CRT_DREG_CLEAR, q.ib[43:28]};
            end
            n.a_dchk = q.bad;
            n.a_naddr = q.noaddr;
            n.fetch = q.stop && !q.bad && !q.noaddr;
            n.release_u = 1'b1;
            if (q.fmt_lock) begin
               n.fmt_lock = 1'b0;
               n.reload_lock = 1'b1;
            end else begin
               n.reload_lock = q.rdig[0];
            end
            n.busy = 1'b0;
            n.phase = CRT_IDLE;
         end
         default: n.phase = CRT_IDLE;
      endcase
   end

   // single state register; reset takes constants only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
         q.hrdy <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // outputs straight from state flops, hresp tied low
   assign hrdata = q.hrdata;
   assign hreadyout = q.hrdy;
   assign hresp = 1'b0;
   assign mem_o = q.mem;
   assign fetch_req = q.fetch;
   assign command_holding_word = q.cmd;
   assign unit_release = q.release_u;
   assign reload_lockout = q.reload_lock;

   // checks all run on hclk and stay quiet while reset is held
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_ptr_wrap_step: assert property (
      q.mem.we |-> q.ptr == ((q.mem.addr == 12'h000) ?
         CRT_MEM_WORDS - 12'h001 : q.mem.addr - 12'h001))
      else $error("pointer did not step down after a store");

   a_noaddr_nowrite: assert property (
      q.noaddr && q.busy |-> !q.mem.we)
      else $error("word stored despite bad base address");

   a_numeric_limit: assert property (
      q.mem.we && q.numeric |-> q.wcnt <= CRT_NUM_WORDS)
      else $error("numeric format stored too many words");

   a_band8_alone: assert property (
      start && q.b2.unit_ok && q.b2.fmt_sel == 8'h80
      |=> q.a_nfmt && !q.busy && q.dreg == 44'h00000000000)
      else $error("band 8 alone did not raise no-format alarm");

   a_bad_pointer: assert property (
      $rose(q.bad) |-> q.ptr == ptr_dec($past(q.ptr)))
      else $error("pointer wrong after digit check");

   a_reload_parity: assert property (
      q.phase == CRT_DONE && !q.fmt_lock
      |=> q.reload_lock == $past(q.rdig[0]) && !q.busy)
      else $error("reload lockout does not follow digit parity");

   a_done_dreg: assert property (
      q.phase == CRT_DONE && !q.bad
      |=> q.dreg[43:16] == CRT_DREG_CLEAR && q.pc == $past(q.pc) + 12'h001)
      else $error("completion left wrong shift register or counter");

   a_pile_sign: assert property (
      q.phase == CRT_XFER && q.bad && stb
      |=> q.dreg[39:0] == $past(q.dreg[39:0]) && !q.mem.we)
      else $error("digits after error did not pile at sign end");

   a_cw_nostore: assert property (
      q.stop && q.busy |-> !q.mem.we)
      else $error("word stored after control word");

   a_nunit_clear: assert property (
      start && !q.b2.unit_ok
      |=> q.a_nunit && !q.busy && q.ptr == $past(q.base) &&
          q.dreg == 44'h00000000000)
      else $error("missing input unit not handled");

   a_band8_reload: assert property (
      q.phase == CRT_DONE && q.fmt_lock |=> q.reload_lock && !q.fmt_lock)
      else $error("format lockout did not leave reload lockout set");

   a_store_busy: assert property (
      q.mem.we |-> q.busy && q.phase != CRT_IDLE)
      else $error("word stored outside a transfer");

   a_fill_zero: assert property (
      q.phase == CRT_FILL
      |=> !q.mem.we || q.mem.data == 44'h00000000000)
      else $error("numeric fill stored a nonzero word");
endmodule
`default_nettype wire

/* inc/crt_pkg.sv */
// constants, carriers and state layout of the card read transfer block
package crt_pkg;
   // installed storage size in words
   localparam logic [11:0] CRT_MEM_WORDS   = 12'hFA0;
   // register byte offsets
   localparam logic [4:0]  CRT_REG_CTRL    = 5'h00;
   localparam logic [4:0]  CRT_REG_BASE    = 5'h04;
   localparam logic [4:0]  CRT_REG_STATUS  = 5'h08;
   localparam logic [4:0]  CRT_REG_PTR     = 5'h0C;
   localparam logic [4:0]  CRT_REG_PC      = 5'h10;
   // control register fields
   localparam int          CRT_GO_BIT      = 31;
   localparam int          CRT_LOCK_LSB    = 0;
   localparam int          CRT_CWOPT_LSB   = 4;
   // format band select bits (bit n is band n+1)
   localparam int          CRT_FMT_BAND8   = 7;
   localparam int          CRT_FMT_NUMERIC = 5;
   // word layout and counts
   localparam logic [3:0]  CRT_LAST_DIGIT  = 4'hA;
   localparam logic [3:0]  CRT_HI_LAST     = 4'h5;
   localparam logic [3:0]  CRT_NUM_WORDS   = 4'hD;
   localparam logic [3:0]  CRT_DIGIT_MAX   = 4'h9;
   localparam logic [3:0]  CRT_SIGN_CW     = 4'h6;
   localparam logic [3:0]  CRT_SIGN_BMOD   = 4'h8;
   localparam logic [27:0] CRT_DREG_CLEAR  = 28'h0000000;

   typedef enum logic [1:0] {CRT_IDLE, CRT_XFER, CRT_FILL, CRT_DONE}
      crt_phase_type;

   // pins from the card buffer unit
   typedef struct packed {
      logic       strobe;
      logic [3:0] digit;
      logic       band_end;
      logic       zeros_ok;
      logic       unit_ok;
      logic [7:0] fmt_sel;
   } crt_buf_type;

   // storage write port
   typedef struct packed {
      logic        we;
      logic [11:0] addr;
      logic [43:0] data;
   } crt_mem_type;

   typedef struct packed {
      crt_phase_type phase;
      crt_buf_type   b1;
      crt_buf_type   b2;
      logic          stb3;
      logic          hrdy;
      logic          wr_pend;
      logic [4:0]    widx;
      logic [31:0]   hrdata;
      logic [3:0]    rdig;
      logic [3:0]    vdig;
      logic [11:0]   base;
      logic [11:0]   ptr;
      logic [11:0]   pc;
      logic [43:0]   dreg;
      logic [43:0]   ib;
      logic          ib_full;
      logic [3:0]    dcnt;
      logic [3:0]    wcnt;
      logic          numeric;
      logic          stop;
      logic          bad;
      logic          noaddr;
      logic          busy;
      logic          a_nfmt;
      logic          a_nunit;
      logic          a_naddr;
      logic          a_dchk;
      logic          reload_lock;
      logic          fmt_lock;
      logic          bmod;
      logic          fetch;
      logic          release_u;
      logic [43:0]   cmd;
      crt_mem_type   mem;
   } crt_state_type;
endpackage

/* verif/crt_buf_model.sv */
// card buffer unit model: delivers band digits at its own slow pace
`timescale 1ns/1ps
`default_nettype none
module crt_buf_model (
   input  wire logic                hclk,
   output var crt_pkg::crt_buf_type buf_o
);
   import crt_pkg::*;

   initial buf_o = '0;

   // seven zeros flag and band choice per card
   task setup(input logic zok, input logic uok, input logic [7:0] fmt);
      @(posedge hclk);
      buf_o.band_end <= 1'b0;
      buf_o.zeros_ok <= zok;
      buf_o.unit_ok  <= uok;
      buf_o.fmt_sel  <= fmt;
      repeat (4) @(posedge hclk);
   endtask

   // one digit per strobe, set up before the rise
   task put_digit(input logic [3:0] d);
      buf_o.digit  <= d;
      @(posedge hclk);
      buf_o.strobe <= 1'b1;
      repeat (4) @(posedge hclk);
      buf_o.strobe <= 1'b0;
      repeat (3) @(posedge hclk);
      // hold time over: the line no longer shows the digit
      buf_o.digit  <= ~d;
      @(posedge hclk);
   endtask

   // eleven digits, sign first, make one word
   task put_word(input logic [43:0] w);
      for (int i = 10; i >= 0; i--) put_digit(w[i*4 +: 4]);
   endtask

   // band end only after the last digit settled
   task end_band;
      repeat (3) @(posedge hclk);
      buf_o.band_end <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* verif/crt_card_read_tb_top.sv */
// self-checking bench for the card read transfer block
`timescale 1ns/1ps
`default_nettype none
module crt_card_read_tb_top;
   import crt_pkg::*;
   logic        hclk    = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel    = 1'b0;
   logic        hwrite  = 1'b0;
   logic [1:0]  htrans  = 2'h0;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic        hreadyout, hresp, fetch, rel, lock;
   logic [31:0] hrdata, rd, st, pt, pc;
   logic [43:0] cmd;
   logic [43:0] card [13];
   logic [11:0] wa [$];
   logic [43:0] wd [$];
   crt_buf_type bus;
   crt_mem_type mem;
   int          fail_count, compares, cyc, nfetch, nrel;

   always #10 hclk = ~hclk;

   crt_card_read i_crt_card_read (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .buf_i(bus), .mem_o(mem), .fetch_req(fetch),
      .command_holding_word(cmd), .unit_release(rel),
      .reload_lockout(lock));

   crt_buf_model i_crt_buf_model (.hclk(hclk), .buf_o(bus));

   // collect storage writes and end pulses; cut a hang short
   always @(posedge hclk) begin
      cyc++;
      if (mem.we === 1'b1) begin
         wa.push_back(mem.addr);
         wd.push_back(mem.data);
      end
      if (fetch === 1'b1) nfetch++;
      if (rel === 1'b1) nrel++;
      if (cyc == 40000) begin
         fail_count++;
         finish_test;
      end
   end

   task finish_test;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task chk(input logic [43:0] seen, input logic [43:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one single transfer; read data is taken at the data phase end
   task ahb(input logic wr, input logic [4:0] a, input logic [31:0] wv);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {27'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wv;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // one card: program, start, deliver band, wait for idle
   task run(input logic [11:0] base, input logic [7:0] ctl,
            input logic [7:0] fmt, input logic zok, input logic uok,
            input int n);
      int k;
      wa.delete();
      wd.delete();
      nfetch = 0;
      nrel = 0;
      i_crt_buf_model.setup(zok, uok, fmt);
      ahb(1'b1, CRT_REG_BASE, {20'h0, base});
      ahb(1'b1, CRT_REG_PC, 32'h0000_0100);
      ahb(1'b1, CRT_REG_CTRL, {24'h800000, ctl});
      for (k = 0; k < n; k++) i_crt_buf_model.put_word(card[k]);
      i_crt_buf_model.end_band;
      k = 0;
      do begin
         ahb(1'b0, CRT_REG_STATUS, 32'h0);
         k++;
      end while (rd[1] !== 1'b0 && k < 300);
      st = rd;
      chk({43'h0, st[1]}, 44'h0);
      chk({43'h0, hresp}, 44'h0);
      ahb(1'b0, CRT_REG_PTR, 32'h0);
      pt = rd;
      ahb(1'b0, CRT_REG_PC, 32'h0);
      pc = rd;
   endtask

   // stored words against the card, at descending addresses
   task chk_words(input logic [11:0] base, input int n);
      chk(44'(wa.size()), 44'(n));
      for (int k = 0; k < n; k++) begin
         chk({32'h0, wa[k]}, {32'h0, base - 12'(k)});
         chk(wd[k], card[k]);
      end
   endtask

   task t_basic;
      card[0] = 44'h1_1234567890;
      card[1] = 44'h0_9876543210;
      card[2] = 44'h5_0000000001;
      run(12'h002, 8'h01, 8'h01, 1'b1, 1'b1, 3);
      chk_words(12'h002, 3);
      chk({12'h0, pt}, 44'hF9F);
      chk({12'h0, pc}, 44'h101);
      chk(44'(nrel), 44'h1);
      ahb(1'b0, 5'h14, 32'h0);
      chk({12'h0, rd}, 44'h0);
   endtask

   task t_lock;
      card[0] = 44'h0_5555555555;
      for (int r = 0; r < 10; r++) begin
         run(12'h040, {4'h0, 4'(r)}, 8'h01, 1'b1, 1'b1, 1);
         chk({43'h0, lock}, 44'(r % 2));
      end
      run(12'h040, 8'h00, 8'h81, 1'b1, 1'b1, 1);
      chk({43'h0, st[3]}, 44'h0);
      chk({43'h0, lock}, 44'h1);
      run(12'h040, 8'h00, 8'h80, 1'b1, 1'b1, 1);
      chk({43'h0, st[3]}, 44'h1);
      chk({12'h0, pt}, 44'h040);
      chk(44'(wa.size()), 44'h0);
      // sign 9 with lockout digit 8: stored as 1, digit acts as even
      card[0] = 44'h9_0000000005;
      run(12'h040, 8'h08, 8'h01, 1'b1, 1'b1, 1);
      chk(wd[0], 44'h1_0000000005);
      chk({43'h0, st[7]}, 44'h1);
      chk({43'h0, lock}, 44'h0);
   endtask

   task t_ctl;
      for (int v = 0; v < 10; v++) begin
         card[0] = 44'h0_1111111111;
         card[1] = {4'(6 + (v / 2) % 2), 40'h0000000042};
         card[2] = 44'h1_2222222222;
         run(12'h030, {4'(v), 4'h0}, 8'h01, 1'b1, 1'b1, 3);
         if (v % 2 == 0) begin
            chk_words(12'h030, 1);
            chk(44'(nfetch), 44'h1);
            chk({43'h0, st[6]}, 44'h1);
            chk(cmd, card[1]);
         end else begin
            chk_words(12'h030, 3);
            chk(44'(nfetch), 44'h0);
            chk({43'h0, st[6]}, 44'h0);
         end
      end
   endtask

   task t_edges;
      card[0] = 44'h0_3333333333;
      card[1] = 44'h0_4444444444;
      run(12'h050, 8'h00, 8'h01, 1'b0, 1'b1, 2);
      chk_words(12'h050, 1);
      for (int k = 2; k < 13; k++) card[k] = 44'h0;
      run(12'h060, 8'h00, 8'h20, 1'b1, 1'b1, 2);
      chk_words(12'h060, 13);
      card[1] = 44'h6_0000000099;
      run(12'h060, 8'h00, 8'h20, 1'b1, 1'b1, 2);
      chk_words(12'h060, 1);
      run(12'h070, 8'h00, 8'h01, 1'b1, 1'b0, 1);
      chk({43'h0, st[2]}, 44'h1);
      chk({12'h0, pt}, 44'h070);
      run(12'hFA5, 8'h00, 8'h01, 1'b1, 1'b1, 2);
      chk({43'h0, st[4]}, 44'h1);
      chk(44'(wa.size()), 44'h0);
      chk({12'h0, pt}, 44'hFA5);
      card[0] = 44'h0_12C4567890;
      run(12'h020, 8'h00, 8'h01, 1'b1, 1'b1, 2);
      chk({43'h0, st[5]}, 44'h1);
      chk({12'h0, pt}, 44'h01F);
   endtask

   // reset for two cycles, then the scenarios in turn
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_basic;
      t_lock;
      t_ctl;
      t_edges;
      finish_test;
   end
endmodule
`default_nettype wire
